// file: design/rx_filter.sv
// Purpose: Hysteresis and debounce between bus comparators and receive pin
// Assumes: Comparator levels synchronised; both never high together
// Notes: Spikes shorter than the debounce count never reach the output
module rx_filter import sp_pkg::*; (
    // Clock, reset, enable
    input logic clk,
    input logic rstn,
    input logic ce,
    // Comparator side
    rx_if.filt cmp
);
    logic hyst_r;
    logic rx_r;
    logic [DEB_W-1:0] cnt_r;

    // Hold between thresholds, recessive after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hyst_r <= 1'b1;
        end else if (ce) begin
            if (cmp.below_lo) begin
                hyst_r <= 1'b0;
            end else if (cmp.above_hi) begin
                hyst_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_r <= 1'b1;
            cnt_r <= '0;
        end else if (ce) begin
            if (hyst_r == rx_r) begin
                cnt_r <= '0;
            end else if (cnt_r == DEB_W'(DEBOUNCE_CYC - 1)) begin
                rx_r <= hyst_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    assign cmp.rx = rx_r;

    hyst_low_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && cmp.below_lo |=> !hyst_r) else $error("hysteresis missed low threshold");
    hyst_high_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && cmp.above_hi && !cmp.below_lo |=> hyst_r)
        else $error("hysteresis missed high threshold");
    debounce_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(rx_r) |-> $past(cnt_r) == DEB_W'(DEBOUNCE_CYC - 1) && rx_r == $past(hyst_r))
        else $error("receive output changed before debounce");
endmodule

// file: design/rx_if.sv
// Purpose: Carries comparator levels to the receive filter and its result back
// Assumes: Levels already synchronised to the system clock
// Notes: None
interface rx_if;
    logic below_lo;
    logic above_hi;
    logic rx;
    modport core(output below_lo, output above_hi, input rx);
    modport filt(input below_lo, input above_hi, output rx);
endinterface

// file: design/shared_pin_serial_port.sv
// Purpose: Pin logic, mode control and two-wire serial port on shared pins
// Assumes: sp_clk is the enable pin wired as a clock; master waits a few
//          system clocks after the serial entry trigger before clocking
// Notes: Clock enable freezes system-clock state only
// ********************************************************************
// What this block does
// - Low transmit drives bus dominant, high recessive
// - Open transmit input reads high
// - No transmission in sleep, thermal, reset
// - Receive follows bus with threshold hysteresis
// - Debounce filters bus spikes before receive
// - Enable fall plus held transmit enters low power
// - Enable rise returns standby to normal
// - Enable fall accepted whatever the bus state
// - Enable low, transmit fall in window: serial
// - Open enable pin reads low
// - Enable held high keeps normal mode
// - Serial mode: enable clocks, transmit is data
// - Command byte: direction, length, start address
// - Direction zero writes, one reads
// - Length code gives one, two, four, eight
// - Last byte of the burst leaves serial mode
// - MSB first, address increments per byte
// - Device samples master bits on falling edge
// - Device drives read data on rising edge
// - Serial port is slave only
// - Thirty-two eight-bit registers by address
// ********************************************************************
module shared_pin_serial_port import sp_pkg::*; (
    // System clock, reset, enable
    input logic clk,
    input logic rstn,
    input logic ce,
    // Serial clock from the enable pin
    input logic sp_clk,
    // Enable and transmit pins
    input logic en_pin,
    input logic tx_in,
    output logic tx_out,
    output logic tx_oe,
    output logic tx_pullup_en,
    output logic en_pulldown_en,
    // Receive pin
    output logic rx_out,
    // Bus front end
    input logic bus_below_lo,
    input logic bus_above_hi,
    output logic bus_dominant,
    // Device status and straps
    input logic thermal_sd,
    input logic master_rst,
    input logic remote_wake,
    input logic sleep_option,
    // Mode and register image
    output logic [1:0] mode,
    output logic [REG_COUNT-1:0][DATA_W-1:0] reg_image
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int SYNC_W = 10;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h002;

    mode_t state_r;
    mode_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [1:0] mode_nxt;
    logic sp_mode_r;
    logic link_rst_n;
    logic bus_dom_r;
    logic en_d;
    logic tx_d;
    logic wr_tog_d;
    logic [REG_COUNT-1:0][DATA_W-1:0] mirror_r;
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync_q;
    logic en_s;
    logic tx_s;
    logic thermal_s;
    logic mrst_s;
    logic wake_s;
    logic sleep_s;
    logic done_s;
    logic wr_tog_s;
    logic en_fall;
    logic en_rise;
    logic tx_fall;

    // Link domain
    logic [REG_COUNT-1:0][DATA_W-1:0] regs_r;
    logic [3:0] byte_cnt_r;
    logic [2:0] bit_cnt_r;
    logic [DATA_W-1:0] shift_r;
    logic [DATA_W-1:0] shift_nxt;
    logic [DATA_W-1:0] cmd_r;
    logic [ADDR_W-1:0] addr_r;
    logic done_r;
    logic wr_tog_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic sda_out_r;
    logic sda_oe_r;
    logic byte_end;
    logic data_phase;
    logic is_read;
    logic wr_stb;

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    assign tx_pullup_en = 1'b1;
    assign en_pulldown_en = 1'b1;

    assign async_in = {wr_tog_r, done_r, bus_above_hi, bus_below_lo, sleep_option,
                       remote_wake, master_rst, thermal_sd, tx_in, en_pin};

    sync2 #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .d(async_in),
        .q(sync_q)
    );

    assign en_s = sync_q[0];
    assign tx_s = sync_q[1];
    assign thermal_s = sync_q[2];
    assign mrst_s = sync_q[3];
    assign wake_s = sync_q[4];
    assign sleep_s = sync_q[5];
    assign done_s = sync_q[8];
    assign wr_tog_s = sync_q[9];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_d <= 1'b0;
            tx_d <= 1'b1;
            wr_tog_d <= 1'b0;
        end else if (ce) begin
            en_d <= en_s;
            tx_d <= tx_s;
            wr_tog_d <= wr_tog_s;
        end
    end

    assign en_fall = en_d && !en_s;
    assign en_rise = !en_d && en_s;
    assign tx_fall = tx_d && !tx_s;

    // ****************************************************************
    // Receive path
    // ****************************************************************
    rx_if rxb();
    assign rxb.below_lo = sync_q[6];
    assign rxb.above_hi = sync_q[7];

    rx_filter u_rx (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .cmp(rxb)
    );

    assign rx_out = rxb.rx;

    // ****************************************************************
    // Mode control
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_NORMAL: begin
                cnt_nxt = '0;
                if (en_fall) begin
                    state_nxt = ST_EN_LOW;
                end
            end
            ST_EN_LOW: begin
                if (en_rise) begin
                    state_nxt = ST_NORMAL;
                    cnt_nxt = '0;
                end else if (tx_fall && cnt_r < CNT_W'(SERIAL_ENTRY_CYC) && !done_s) begin
                    state_nxt = ST_SERIAL;
                end else if (!tx_s) begin
                    cnt_nxt = '0;
                end else if (cnt_r == CNT_W'(STANDBY_HOLD_CYC - 1)) begin
                    state_nxt = sleep_s ? ST_SLEEP : ST_STANDBY;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 12'h001;
                end
            end
            ST_STANDBY: begin
                if (en_rise || wake_s) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_SLEEP: begin
                if (wake_s) begin
                    state_nxt = ST_NORMAL;
                end
            end
            ST_SERIAL: begin
                if (done_s) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
                cnt_nxt = '0;
            end
        endcase
    end

    always_comb begin
        case (state_nxt)
            ST_STANDBY: mode_nxt = MODE_STANDBY;
            ST_SLEEP: mode_nxt = MODE_SLEEP;
            ST_SERIAL: mode_nxt = MODE_SERIAL;
            default: mode_nxt = MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_NORMAL;
            cnt_r <= '0;
            mode <= MODE_NORMAL;
            sp_mode_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mode <= mode_nxt;
            sp_mode_r <= (state_nxt == ST_SERIAL);
        end
    end

    // ****************************************************************
    // Bus driver
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_dom_r <= 1'b0;
        end else if (ce) begin
            bus_dom_r <= (state_r == ST_NORMAL) && !tx_s && !thermal_s && !mrst_s;
        end
    end

    assign bus_dominant = bus_dom_r;

    // ****************************************************************
    // Serial link, clocked by the enable pin
    // ****************************************************************
    // Held in reset outside serial mode; the clock is idle at release
    assign link_rst_n = rstn && sp_mode_r;

    assign shift_nxt = {shift_r[DATA_W-2:0], tx_in};
    assign byte_end = (bit_cnt_r == 3'h7) && !done_r;
    assign data_phase = (byte_cnt_r != 4'h0);
    assign is_read = cmd_r[CMD_RW_POS];
    assign wr_stb = byte_end && data_phase && !is_read;

    always_ff @(negedge sp_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
        end else if (!done_r) begin
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always_ff @(negedge sp_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            byte_cnt_r <= '0;
            cmd_r <= '0;
            addr_r <= '0;
            done_r <= 1'b0;
        end else if (byte_end) begin
            byte_cnt_r <= byte_cnt_r + 4'h1;
            if (!data_phase) begin
                cmd_r <= shift_nxt;
                addr_r <= shift_nxt[ADDR_MSB_POS:0];
            end else begin
                addr_r <= addr_r + 5'h01;
                if (byte_cnt_r == burst_bytes(cmd_r[LEN_HI_POS:LEN_LO_POS])) begin
                    done_r <= 1'b1;
                end
            end
        end
    end

    // Register file keeps its contents across frames
    always_ff @(negedge sp_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= REG_RESET;
            end
            wr_tog_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= REG_RESET;
        end else if (wr_stb) begin
            regs_r[addr_r] <= shift_nxt;
            wr_addr_r <= addr_r;
            wr_data_r <= shift_nxt;
            wr_tog_r <= ~wr_tog_r;
        end
    end

    // Read data leaves on the rising edge, only when asked for
    always_ff @(posedge sp_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else begin
            sda_oe_r <= data_phase && is_read && !done_r;
            sda_out_r <= regs_r[addr_r][3'h7 - bit_cnt_r];
        end
    end

    assign tx_out = sda_out_r;
    assign tx_oe = sda_oe_r;

    // ****************************************************************
    // Register image in the system domain
    // ****************************************************************
    // Write address and data stay put until the next toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mirror_r[i] <= REG_RESET;
            end
        end else if (ce && (wr_tog_s != wr_tog_d)) begin
            mirror_r[wr_addr_r] <= wr_data_r;
        end
    end

    assign reg_image = mirror_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_en_fall;
        state_r == ST_NORMAL && en_fall && ce;
    endsequence
    sequence s_tx_trigger;
        state_r == ST_EN_LOW && ce && !en_rise && tx_fall &&
            cnt_r < CNT_W'(SERIAL_ENTRY_CYC) && !done_s;
    endsequence
    sequence s_tx_held;
        state_r == ST_EN_LOW && ce && !en_rise && tx_s &&
            cnt_r == CNT_W'(STANDBY_HOLD_CYC - 1);
    endsequence

    tx_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && state_r == ST_NORMAL && !tx_s && !thermal_s && !mrst_s |=> bus_dominant)
        else $error("bus not dominant for low transmit");
    tx_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && (thermal_s || mrst_s || state_r == ST_SLEEP) |=> !bus_dominant)
        else $error("bus driven while transmission suppressed");
    en_fall_a: assert property (@(posedge clk) disable iff (!rstn)
        s_en_fall |=> state_r == ST_EN_LOW) else $error("enable fall not accepted");
    hold_time_a: assert property (@(posedge clk) disable iff (!rstn)
        s_tx_held |=> (state_r == ST_STANDBY || state_r == ST_SLEEP) && mode != MODE_NORMAL)
        else $error("low power not entered after hold time");
    en_rise_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && state_r == ST_STANDBY && en_rise |=> state_r == ST_NORMAL ##1 mode == MODE_NORMAL)
        else $error("standby not left on enable rise");
    en_high_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && state_r == ST_NORMAL && en_s |=> state_r == ST_NORMAL)
        else $error("normal mode left with enable high");
    serial_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        s_tx_trigger |=> sp_mode_r && mode == MODE_SERIAL)
        else $error("serial mode not entered on trigger");
    sp_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && state_r == ST_SERIAL && done_s |=> !sp_mode_r ##1 !tx_oe)
        else $error("serial mode not left after last byte");
    mirror_write_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr_tog_s != wr_tog_d |=> mirror_r[$past(wr_addr_r)] == $past(wr_data_r))
        else $error("register image missed a write");
    cmd_parse_a: assert property (@(negedge sp_clk) disable iff (!link_rst_n)
        byte_end && !data_phase |=> cmd_r == $past(shift_nxt) &&
            addr_r == cmd_r[ADDR_MSB_POS:0])
        else $error("command byte not captured");
    wr_store_a: assert property (@(negedge sp_clk) disable iff (!link_rst_n)
        wr_stb |=> wr_data_r == $past(shift_nxt) && wr_addr_r == $past(addr_r) &&
            wr_tog_r != $past(wr_tog_r))
        else $error("write byte not stored");
    addr_inc_a: assert property (@(negedge sp_clk) disable iff (!link_rst_n)
        byte_end && data_phase |=> addr_r == $past(addr_r) + 5'h01)
        else $error("address did not increment");
    burst_len_a: assert property (@(negedge sp_clk) disable iff (!link_rst_n)
        $rose(done_r) |-> byte_cnt_r == burst_bytes(cmd_r[LEN_HI_POS:LEN_LO_POS]) + 4'h1)
        else $error("burst length mismatch");
    read_drive_a: assert property (@(posedge sp_clk) disable iff (!link_rst_n)
        !(data_phase && is_read) |=> !sda_oe_r)
        else $error("data driven outside read phase");
endmodule

// file: design/sp_pkg.sv
// Purpose: Shared constants, types and helpers for the shared-pin serial port
// Assumes: System clock period of 100 ns
// Notes: Trigger and debounce times are plain defaults, not device figures
package sp_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STANDBY_HOLD_NS = 40000;
    localparam int unsigned SERIAL_ENTRY_NS = 20000;
    localparam int unsigned DEBOUNCE_NS = 2000;
    // Least time: round up
    localparam int unsigned STANDBY_HOLD_CYC =
        (STANDBY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time: round down, at least one cycle
    localparam int unsigned SERIAL_ENTRY_CYC =
        (SERIAL_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 : (SERIAL_ENTRY_NS / CLK_PERIOD_NS);
    localparam int unsigned DEBOUNCE_CYC =
        (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam int DEB_W = 8;

    // ****************************************************************
    // Register file and command byte layout
    // ****************************************************************
    localparam int REG_COUNT = 32;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CMD_RW_POS = 7;
    localparam int LEN_HI_POS = 6;
    localparam int LEN_LO_POS = 5;
    localparam int ADDR_MSB_POS = 4;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Modes
    // ****************************************************************
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_SERIAL = 2'h3;

    typedef enum logic [2:0] {ST_NORMAL, ST_EN_LOW, ST_STANDBY, ST_SLEEP, ST_SERIAL} mode_t;

    // Data bytes in a burst for a two-bit length code
    function automatic logic [3:0] burst_bytes(input logic [1:0] len);
        return 4'h1 << len;
    endfunction

endpackage

// file: design/sync2.sv
// Purpose: Two-flop synchroniser for a vector of independent levels
// Assumes: Each bit is an unrelated level
// Notes: First stage feeds only the second stage
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock, reset, enable
    input logic clk,
    input logic rstn,
    input logic ce,
    // Levels
    input logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else if (ce) begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// file: testbench/mcu_master.sv
// Purpose: Microcontroller model on the enable and transmit pins
// Assumes: Link clock of 80 ns, running only inside frames
// Notes: Released data line reads high through the pull-up
module mcu_master (
    // Pins
    output logic en,
    output logic tx_drv,
    output logic tx_drv_oe,
    input wire logic tx_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wbuf [8];
    logic [7:0] rd_byte;
    logic rd_valid;
    initial begin
        en = 1'b1;
        tx_drv = 1'b1;
        tx_drv_oe = 1'b1;
        rd_byte = 8'h00;
        rd_valid = 1'b0;
    end
    task automatic pins(input logic e, input logic t);
        en = e;
        tx_drv = t;
    endtask
    // One link clock: set after rise, take at fall
    task automatic bit_xfer(input logic d, output logic q);
        en = 1'b1;
        #2 tx_drv = d;
        #38 en = 1'b0;
        q = tx_wire;
        #40;
    endtask
    // ****************************************************************
    // Whole frame, always started here
    // ****************************************************************
    task automatic frame(input logic [7:0] cmd);
        logic q;
        int n;
        n = 1 << cmd[6:5];
        en = 1'b0;
        #300 tx_drv = 1'b0;
        #1000;
        for (int i = 7; i >= 0; i--) bit_xfer(cmd[i], q);
        tx_drv_oe = !cmd[7];
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_xfer(wbuf[b][i], q);
                rd_byte[i] = q;
            end
            if (cmd[7]) begin
                rd_valid = 1'b1;
                #1 rd_valid = 1'b0;
            end
        end
        // Spare clock after the last byte, to be ignored by the device
        bit_xfer(1'b1, q);
        #1000 tx_drv_oe = 1'b1;
        en = 1'b1;
        tx_drv = 1'b1;
        #1000;
    endtask
endmodule

// file: testbench/shared_pin_serial_port_bench.sv
// Purpose: Self-checking bench for the shared-pin serial port
// Assumes: Link clock made by the master model
// Notes: Read bytes are compared against a queue of expected values
module shared_pin_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sp_pkg::*;
    logic clk, rstn, ce, en, tx_drv, tx_drv_oe, tx_wire, tx_out, tx_oe;
    logic pu, pd, rx_out, below, above, bus_dom, thermal, mrst, rwake, sleep_opt;
    logic [1:0] mode;
    logic [REG_COUNT-1:0][DATA_W-1:0] reg_image;
    logic [7:0] mem [32];
    logic [7:0] exp_q [$];
    logic [4:0] a;
    int compares = 0;
    int miscompares = 0;
    assign tx_wire = tx_oe ? tx_out : (tx_drv_oe ? tx_drv : 1'b1);
    mcu_master u_mcu (.en(en), .tx_drv(tx_drv), .tx_drv_oe(tx_drv_oe), .tx_wire(tx_wire));
    shared_pin_serial_port u_dut (.clk(clk), .rstn(rstn), .ce(ce), .sp_clk(en), .en_pin(en),
        .tx_in(tx_wire), .tx_out(tx_out), .tx_oe(tx_oe), .tx_pullup_en(pu),
        .en_pulldown_en(pd), .rx_out(rx_out), .bus_below_lo(below), .bus_above_hi(above),
        .bus_dominant(bus_dom), .thermal_sd(thermal), .master_rst(mrst),
        .remote_wake(rwake), .sleep_option(sleep_opt), .mode(mode), .reg_image(reg_image));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int k;
        k = 0;
        while (mode !== m && k < 2000) begin
            cyc(1);
            k++;
        end
        if (k == 2000) begin
            miscompares++;
            wrap_up();
        end
    endtask
    // Read data taken by the master
    always @(posedge u_mcu.rd_valid) begin
        if (exp_q.size() == 0) check(8'hff, 8'h00);
        else check(u_mcu.rd_byte, exp_q.pop_front());
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rstn, thermal, mrst, rwake, sleep_opt, below} = 6'h00;
        {ce, above} = 2'h3;
        foreach (mem[i]) mem[i] = 8'h00;
        void'($urandom(6));
        cyc(10);
        rstn = 1'b1;
        check(mode, MODE_NORMAL);
        check(rx_out, 1'b1);
        check(bus_dom, 1'b0);
        check({pu, pd}, 2'h3);
        check(reg_image[31], REG_RESET);
        $display("test reset done");
        ce = 1'b0;
        u_mcu.pins(1'b1, 1'b0);
        cyc(10);
        check(bus_dom, 1'b0); // Frozen while ce is low
        ce = 1'b1;
        cyc(500);
        check(bus_dom, 1'b1);
        check(mode, MODE_NORMAL);
        thermal = 1'b1;
        cyc(5);
        check(bus_dom, 1'b0);
        {thermal, mrst} = 2'h1;
        cyc(5);
        check(bus_dom, 1'b0);
        mrst = 1'b0;
        u_mcu.pins(1'b1, 1'b1);
        cyc(5);
        check(bus_dom, 1'b0);
        $display("test transmit done");
        {below, above} = 2'h2;
        cyc(5);
        {below, above} = 2'h1;
        cyc(30);
        check(rx_out, 1'b1);
        {below, above} = 2'h2;
        cyc(30);
        check(rx_out, 1'b0);
        {below, above} = 2'h0;
        cyc(30);
        check(rx_out, 1'b0);
        $display("test receive done");
        for (int s = 0; s < 2; s++) begin
            sleep_opt = s[0];
            u_mcu.pins(1'b0, 1'b1);
            cyc(300);
            check(mode, MODE_NORMAL);
            wait_mode(s ? MODE_SLEEP : MODE_STANDBY);
            u_mcu.pins(1'b0, 1'b0);
            cyc(5);
            check(bus_dom, 1'b0);
            u_mcu.pins(1'b1, 1'b1);
            cyc(10);
            check(mode, s ? MODE_SLEEP : MODE_NORMAL);
            rwake = 1'b1;
            wait_mode(MODE_NORMAL);
            rwake = 1'b0;
        end
        {below, above} = 2'h1;
        $display("test low power done");
        for (int c = 0; c < 4; c++) begin
            a = 5'($urandom);
            foreach (u_mcu.wbuf[b]) u_mcu.wbuf[b] = 8'($urandom);
            u_mcu.frame({1'b0, 2'(c), a});
            for (int b = 0; b < (1 << c); b++) mem[5'(a + 5'(b))] = u_mcu.wbuf[b];
            foreach (mem[i]) check(reg_image[i], mem[i]);
            check(mode, MODE_NORMAL);
            for (int b = 0; b < (1 << c); b++) exp_q.push_back(mem[5'(a + 5'(b))]);
            u_mcu.frame({1'b1, 2'(c), a});
            check(8'(exp_q.size()), 8'h00);
            check(mode, MODE_NORMAL);
        end
        $display("test serial done");
        wrap_up();
    end
endmodule
